// ---- hw/trsb_sample_buffer.sv ----
`timescale 1ns/100ps
`default_nettype none

// How it works
// - narrowband: three words straight into output
// - each strobe latches word into own rank
// - rank three end copies words to holding
// - request after transfer; 29-bit word read
// - groups repeat until host stops acknowledging
// - wideband store: three ranks of 9 bits
// - wideband samples rotate ranks one-two-three
// - new word shifts its rank one stage
// - all stored: halt, shift all ranks together
// - each new packed word raises request
// - store holds 16,386 samples, 5462 deep
// - chain: five 1024, one 341, two-stage output
// - wideband 40 kHz to 10 MHz supported
// - narrowband 5 kHz to 20 kHz supported
// - first shift from stop, then ack falls
// - all-slots mode until reset
module trsb_sample_buffer (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           wide_mode,
   input  wire logic                           conv_done,
   input  wire logic [trsb_pkg::SAMPLE_W-1:0]  conv_word,
   input  wire logic [trsb_pkg::ERR_W-1:0]     error_flag,
   input  wire logic                           host_acknowledge,
   output logic                                word_request,
   output logic      [trsb_pkg::HOST_W-1:0]    host_word,
   output logic                                conversions_halt,
   output logic                                all_slots_mode,
   output logic                                readout_done,
   output logic                                overrun
);

   typedef enum logic [1:0] {
      TRSB_ACQUIRE,
      TRSB_READOUT,
      TRSB_FINISHED
   } trsb_phase_e;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [1:0] next_slot(input logic [1:0] slot_now);
      next_slot = (slot_now == trsb_pkg::SLOT_THREE) ? trsb_pkg::SLOT_ONE : slot_now + 2'h1;
   endfunction

   function automatic logic [trsb_pkg::HOST_W-1:0] pack_word(
      input logic [trsb_pkg::SAMPLE_W-1:0] w1,
      input logic [trsb_pkg::SAMPLE_W-1:0] w2,
      input logic [trsb_pkg::SAMPLE_W-1:0] w3,
      input logic [trsb_pkg::ERR_W-1:0]    err
   );
      logic [trsb_pkg::HOST_W-1:0] word;
      word = '0;
      word[trsb_pkg::RANK1_LSB +: trsb_pkg::SAMPLE_W] = w1;
      word[trsb_pkg::RANK2_LSB +: trsb_pkg::SAMPLE_W] = w2;
      word[trsb_pkg::RANK3_LSB +: trsb_pkg::SAMPLE_W] = w3;
      word[trsb_pkg::ERR_LSB +: trsb_pkg::ERR_W]      = err;
      pack_word = word;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   trsb_phase_e                     phase;
   logic [1:0]                      slot;
   logic                            load;
   logic [trsb_pkg::SAMPLE_W-1:0]   rank_word [trsb_pkg::RANKS];
   logic                            rank3_end;
   logic [trsb_pkg::CNT_W-1:0]      stored;
   logic                            ack_d;
   logic                            ack_fall;
   logic                            shift_pend;
   logic                            shift_fire;
   logic                            shift_d;
   logic [trsb_pkg::PTR_W-1:0]      words_left;
   logic [trsb_pkg::RANKS-1:0]      rank_shift;
   logic [trsb_pkg::SAMPLE_W-1:0]   rank_in;
   logic [trsb_pkg::SAMPLE_W-1:0]   rank_out [trsb_pkg::RANKS];
   logic                            buf_in_valid;
   logic                            buf_in_ready;
   logic [trsb_pkg::HOST_W-1:0]     buf_in_data;
   logic                            buf_out_valid;
   logic                            stop_event;
   logic                            readout_end;

   // a strobe only counts while conversions are permitted
   assign load       = conv_done && !conversions_halt;
   assign stop_event = load && wide_mode && (stored == trsb_pkg::WIDE_LAST);
   assign ack_fall   = ack_d && !host_acknowledge;
   assign readout_end = (words_left == '0) && !shift_pend && !shift_d;

   ////////////////////////////////////////////////////////////////////////////
   // rank rotation
   // the pointer moves on every accepted strobe in both modes, so a group
   // always starts in rank one after reset

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slot <= trsb_pkg::SLOT_ONE;
      end else if (load) begin
         slot <= next_slot(slot);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // narrowband ranks: straight into the first half of the output stage

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < trsb_pkg::RANKS; i++) begin
            rank_word[i] <= '0;
         end
      end else if (load && !wide_mode) begin
         rank_word[slot] <= conv_word;
      end
   end

   // transfer to the holding half one cycle after the rank-three strobe;
   // the strobe writes its word at that same edge, so the group is whole
   // only one cycle later
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rank3_end <= 1'b0;
      end else begin
         rank3_end <= load && !wide_mode && (slot == trsb_pkg::SLOT_THREE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wideband acquisition and readout phase

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= TRSB_ACQUIRE;
      end else begin
         unique case (phase)
            TRSB_ACQUIRE: begin
               if (stop_event) begin
                  phase <= TRSB_READOUT;
               end
            end
            TRSB_READOUT: begin
               if (readout_end) begin
                  phase <= TRSB_FINISHED;
               end
            end
            TRSB_FINISHED: begin
               // stays here until reset; the host may still read the last words
               phase <= TRSB_FINISHED;
            end
         endcase
      end
   end

   // the stop strobe itself is not counted: the count tops out at the last
   // index, and the compare against it marks the final sample
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stored <= '0;
      end else if (load && wide_mode && !stop_event) begin
         stored <= stored + 1'b1;
      end
   end

   // halt blocks every later strobe; only reset lifts it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conversions_halt <= 1'b0;
      end else if (stop_event) begin
         conversions_halt <= 1'b1;
      end
   end

   // readout clocks all ranks at once; rotating clocking returns at reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         all_slots_mode <= 1'b0;
      end else if (stop_event) begin
         all_slots_mode <= 1'b1;
      end
   end

   // raised once the last shift has been pushed toward the host
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         readout_done <= 1'b0;
      end else if (phase == TRSB_READOUT && readout_end) begin
         readout_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readout shift pulses: the stop event gives the first, every falling
   // acknowledge after that gives the next

   // resets to the idle level of the acknowledge, so no false fall follows reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_d <= 1'b0;
      end else begin
         ack_d <= host_acknowledge;
      end
   end

   // one shift in flight at a time: the next waits until the previous word
   // has been pushed and the buffer has room for it
   assign shift_fire = shift_pend && buf_in_ready && !shift_d;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_pend <= 1'b0;
      end else if (stop_event) begin
         shift_pend <= 1'b1;
      end else if (ack_fall && all_slots_mode && words_left != '0) begin
         shift_pend <= 1'b1;
      end else if (shift_fire) begin
         shift_pend <= 1'b0;
      end
   end

   // shifts still owed to the host; the stop event owes a full rank
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         words_left <= '0;
      end else if (stop_event) begin
         words_left <= trsb_pkg::READOUT_WORDS;
      end else if (shift_fire) begin
         words_left <= words_left - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_d <= 1'b0;
      end else begin
         shift_d <= shift_fire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wideband store: each rank shifts on its own strobe while acquiring,
   // all three together while reading out

   // zeros fill in behind the readout, so stale samples never come round again
   assign rank_in = all_slots_mode ? '0 : conv_word;

   for (genvar r = 0; r < trsb_pkg::RANKS; r++) begin : g_rank
      assign rank_shift[r] = wide_mode &&
                             ((load && slot == 2'(r)) || shift_fire);

      trsb_rank_store u_store (
         .sys_clk  (sys_clk),
         .rst      (rst),
         .shift    (rank_shift[r]),
         .in_word  (rank_in),
         .out_word (rank_out[r])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // holding stage toward the host

   always_comb begin
      if (wide_mode) begin
         buf_in_valid = shift_d;
         buf_in_data  = pack_word(rank_out[0], rank_out[1], rank_out[2], error_flag);
      end else begin
         buf_in_valid = rank3_end;
         buf_in_data  = pack_word(rank_word[0], rank_word[1], rank_word[2], error_flag);
      end
   end

   // a narrowband group that finds the buffer full is lost
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overrun <= 1'b0;
      end else begin
         overrun <= rank3_end && !wide_mode && !buf_in_ready;
      end
   end

   trsb_pair_buffer u_hold (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (ack_fall),
      .out_data  (host_word)
   );

   // request stands while a word waits and the host is not acknowledging;
   // an unanswered request simply stays up, which ends the run
   assign word_request = buf_out_valid && !host_acknowledge && !ack_fall;

   // strobes may come as close as one per cycle, so every supported rate
   // works; each rank shifts on every third strobe

endmodule

`default_nettype wire

// ---- hw/trsb_pkg.sv ----
package trsb_pkg;

   // sample and word layout
   localparam int unsigned SAMPLE_W   = 9;
   localparam int unsigned RANKS      = 3;
   localparam int unsigned PACKED_W   = SAMPLE_W * RANKS;
   localparam int unsigned ERR_W      = 2;
   localparam int unsigned HOST_W     = PACKED_W + ERR_W;

   // packed word fields: rank one is the oldest sample, highest sample bits, just below the error bits
   localparam int unsigned RANK1_LSB  = 18;
   localparam int unsigned RANK2_LSB  = 9;
   localparam int unsigned RANK3_LSB  = 0;
   localparam int unsigned ERR_LSB    = 27;

   // wideband chain: five long sections, one short section, two-stage output
   localparam int unsigned SEC_LONG   = 1024;
   localparam int unsigned SEC_LONG_N = 5;
   localparam int unsigned SEC_SHORT  = 341;
   localparam int unsigned OUT_STAGE  = 2;
   localparam int unsigned RANK_DEPTH = SEC_LONG * SEC_LONG_N + SEC_SHORT + OUT_STAGE - 1;
   localparam int unsigned WIDE_TOTAL = RANK_DEPTH * RANKS;
   localparam int unsigned PTR_W      = 13;
   localparam int unsigned CNT_W      = 15;

   localparam logic [PTR_W-1:0] RANK_LAST      = PTR_W'(RANK_DEPTH - 1);
   localparam logic [CNT_W-1:0] WIDE_LAST      = CNT_W'(WIDE_TOTAL - 1);
   localparam logic [PTR_W-1:0] READOUT_WORDS  = PTR_W'(RANK_DEPTH);

   // rank rotation pointer
   localparam logic [1:0] SLOT_ONE   = 2'h0;
   localparam logic [1:0] SLOT_TWO   = 2'h1;
   localparam logic [1:0] SLOT_THREE = 2'h2;

   // supported sampling rates in kHz and the spacing they leave in clock cycles
   localparam int unsigned CLK_KHZ         = 100000;
   localparam int unsigned WIDE_MAX_KHZ    = 10000;
   localparam int unsigned WIDE_MIN_KHZ    = 40;
   localparam int unsigned NARROW_MAX_KHZ  = 20;
   localparam int unsigned NARROW_MIN_KHZ  = 5;
   localparam int unsigned WIDE_MIN_GAP    = CLK_KHZ / WIDE_MAX_KHZ;
   localparam int unsigned NARROW_MIN_GAP  = CLK_KHZ / NARROW_MAX_KHZ;

   // holding buffer
   localparam int unsigned BUF_DEPTH  = 2;

endpackage

// ---- hw/trsb_pair_buffer.sv ----
`timescale 1ns/100ps
`default_nettype none

// two-entry buffer with valid/ready on both sides; head entry drives out_data
module trsb_pair_buffer (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           in_valid,
   output logic                                in_ready,
   input  wire logic [trsb_pkg::HOST_W-1:0]    in_data,
   output logic                                out_valid,
   input  wire logic                           out_ready,
   output logic      [trsb_pkg::HOST_W-1:0]    out_data
);

   logic [trsb_pkg::HOST_W-1:0] second;
   logic [1:0]                  fill;
   logic                        push;
   logic                        pop;

   assign in_ready  = (fill != 2'(trsb_pkg::BUF_DEPTH));
   assign out_valid = (fill != 2'h0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fill <= 2'h0;
      end else if (push && !pop) begin
         fill <= fill + 2'h1;
      end else if (pop && !push) begin
         fill <= fill - 2'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_data <= '0;
         second   <= '0;
      end else begin
         if (pop) begin
            out_data <= (fill == 2'h2) ? second : in_data;
         end else if (push && fill == 2'h0) begin
            out_data <= in_data;
         end
         if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2 && pop))) begin
            second <= in_data;
         end
      end
   end

endmodule

`default_nettype wire

// ---- hw/trsb_rank_store.sv ----
`timescale 1ns/100ps
`default_nettype none

// one rank of the wideband store: a word-wide shift chain held as a ring
// indexed by a pointer; each shift takes in a word and drops the oldest
// into the output stage register
module trsb_rank_store (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           shift,
   input  wire logic [trsb_pkg::SAMPLE_W-1:0]  in_word,
   output logic      [trsb_pkg::SAMPLE_W-1:0]  out_word
);

   logic [trsb_pkg::SAMPLE_W-1:0] chain [trsb_pkg::RANK_DEPTH];
   logic [trsb_pkg::PTR_W-1:0]    ptr;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ptr      <= '0;
         out_word <= '0;
      end else if (shift) begin
         out_word <= chain[ptr];
         ptr      <= (ptr == trsb_pkg::RANK_LAST) ? '0 : ptr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (shift) begin
         chain[ptr] <= in_word;
      end
   end

endmodule

`default_nettype wire

// ---- bench/trsb_buffer_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module trsb_buffer_monitor (
   input wire logic                        sys_clk,
   input wire logic                        rst,
   input wire logic                        wide_mode,
   input wire logic                        host_acknowledge,
   input wire logic                        word_request,
   input wire logic [trsb_pkg::HOST_W-1:0] host_word,
   input wire logic                        conversions_halt,
   input wire logic                        all_slots_mode,
   input wire logic                        readout_done,
   input wire logic                        overrun
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_req_ack_excl: assert property (host_acknowledge |-> !word_request)
      else $error("request high while host acknowledges");
   a_word_holds: assert property (word_request && $past(word_request) |-> $stable(host_word))
      else $error("host word changed under a pending request");
   a_halt_sticks: assert property (conversions_halt |=> conversions_halt)
      else $error("conversion halt dropped");
   a_halt_wide: assert property (conversions_halt |-> wide_mode)
      else $error("conversion halt outside wideband");
   a_slots_halt: assert property (all_slots_mode |-> conversions_halt && wide_mode)
      else $error("all slots mode without store full");
   a_overrun_narrow: assert property (overrun |-> !wide_mode ##1 !overrun)
      else $error("overrun not a narrowband single pulse");
   a_reset_clear: assert property ($fell(rst) |-> !word_request && host_word == '0 && !all_slots_mode)
      else $error("outputs not cleared after reset");
   a_fall_next: assert property ($fell(host_acknowledge) && all_slots_mode && !readout_done
      |-> ##[1:4] (word_request || host_acknowledge))
      else $error("no new word after acknowledge fell");
   a_done_sticks: assert property (readout_done |-> all_slots_mode ##1 readout_done)
      else $error("readout done unstable");

   c_overrun: cover property (overrun);
   c_done: cover property ($rose(readout_done));
   c_read: cover property (word_request ##1 host_acknowledge);
endmodule

bind trsb_sample_buffer trsb_buffer_monitor trsb_buffer_monitor_i (
   .sys_clk, .rst, .wide_mode, .host_acknowledge, .word_request, .host_word,
   .conversions_halt, .all_slots_mode, .readout_done, .overrun
);
`default_nettype wire

// ---- bench/trsb_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// host input channel: acknowledges each request, promptly or slowly
module trsb_host_model (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        enable,
   input  wire logic                        slow,
   input  wire logic                        word_request,
   input  wire logic [trsb_pkg::HOST_W-1:0] host_word,
   output logic                             host_acknowledge,
   output logic                             got,
   output logic      [trsb_pkg::HOST_W-1:0] got_word
);
   int n;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         host_acknowledge <= 1'b0;
         got <= 1'b0;
         got_word <= '0;
         n <= 0;
      end else begin
         got <= 1'b0;
         n <= n + 1;
         // disabled host leaves the request unanswered to end a run
         if (!host_acknowledge && enable && word_request === 1'b1) begin
            if (n >= (slow ? 5 : 0)) begin
               host_acknowledge <= 1'b1;
               got <= 1'b1;
               got_word <= host_word;
               n <= 0;
            end
         end else if (host_acknowledge && n >= (slow ? 3 : 0)) begin
            host_acknowledge <= 1'b0;
            n <= 0;
         end else if (!host_acknowledge) begin
            n <= 0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb_three_rank_sample_buffer.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_three_rank_sample_buffer;
   logic                              sys_clk = 1'b0;
   logic                              rst = 1'b1;
   logic                              wide_mode = 1'b0;
   logic                              conv_done = 1'b0;
   logic [trsb_pkg::SAMPLE_W-1:0]     conv_word = '0;
   logic [trsb_pkg::ERR_W-1:0]        error_flag = '0;
   logic                              host_on = 1'b0;
   logic                              slow = 1'b0;
   logic                              host_acknowledge, word_request, got;
   logic                              conversions_halt, all_slots_mode, readout_done, overrun;
   logic [trsb_pkg::HOST_W-1:0]       host_word, got_word;
   int                                miscompares = 0;
   int                                check_count = 0;

   always #5 sys_clk = ~sys_clk;

   trsb_sample_buffer trsb_sample_buffer_i (
      .sys_clk, .rst, .wide_mode, .conv_done, .conv_word, .error_flag, .host_acknowledge,
      .word_request, .host_word, .conversions_halt, .all_slots_mode, .readout_done, .overrun
   );

   trsb_host_model trsb_host_model_i (
      .sys_clk, .rst, .enable(host_on), .slow, .word_request, .host_word,
      .host_acknowledge, .got, .got_word
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [8:0] smp(input int n);
      return 9'(n * 7 + 3);
   endfunction

   function automatic logic [31:0] word_of(input int k, input logic [1:0] e);
      return {3'h0, e, smp(3 * k), smp(3 * k + 1), smp(3 * k + 2)};
   endfunction

   task automatic strobe(input logic [8:0] w);
      conv_word = w;
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
   endtask

   // bounded wait for the host to take the next word
   task automatic take(input logic [31:0] exp);
      int i;
      for (i = 0; i < 200 && got !== 1'b1; i++)
         tick(1);
      if (i == 200) begin
         miscompares++;
         report_and_stop();
      end else begin
         check(got_word, exp);
         tick(1);
      end
   endtask

   task automatic do_reset(input logic wide);
      rst = 1'b1;
      wide_mode = wide;
      tick(3);
      check({word_request, conversions_halt, all_slots_mode, readout_done, overrun}, 0);
      check(host_word, 0);
      rst = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // three groups with the host idle: two fill the buffer, the third is lost
   task automatic narrow_run;
      int g;
      int s;
      for (g = 0; g < 3; g++) begin
         error_flag = 2'(g + 1);
         for (s = 0; s < 3; s++) begin
            tick(g == 0 ? trsb_pkg::NARROW_MIN_GAP - 1 : 2);
            strobe(smp(3 * g + s));
         end
         check(word_request, g > 0);
         tick(1);
         check(word_request, 1);
         check(overrun, g == 2);
      end
      tick(20);
      check(word_request, 1);
      host_on = 1'b1;
      take(word_of(0, 2'h1));
      slow = 1'b1;
      take(word_of(1, 2'h2));
      tick(30);
      check(word_request, 0);
   endtask

   // fill the whole store back to back, then read every packed word
   task automatic wide_run;
      int i;
      host_on = 1'b0;
      slow = 1'b0;
      error_flag = 2'h3;
      do_reset(1'b1);
      conv_done = 1'b1;
      for (i = 0; i < 16386; i++) begin
         conv_word = smp(i);
         tick(1);
         if (i == 16384)
            check(conversions_halt, 0);
      end
      conv_done = 1'b0;
      tick(1);
      check({conversions_halt, all_slots_mode}, 2'h3);
      strobe(9'h1ff);
      host_on = 1'b1;
      for (i = 0; i < 5462; i++) begin
         slow = (i < 3 || i > 5458);
         take(word_of(i, 2'h3));
      end
      tick(40);
      check({readout_done, word_request}, 2'h2);
   endtask

   initial begin
      do_reset(1'b0);
      narrow_run();
      wide_run();
      do_reset(1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
